// file: hw/host_port_dev.sv
`default_nettype none
module host_port_dev #(
   parameter int NREG = 128
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   host_port_if.dev bus,
   input wire host_port_pkg::bus_form_e mode_i,
   input wire logic out_edge_select_i,
   output logic reg_wr_o,
   output logic [host_port_pkg::ADDR_W-1:0] reg_addr_o,
   output logic [host_port_pkg::DATA_W-1:0] reg_data_o
);
   import host_port_pkg::*;

   if (NREG < 1 || NREG > (1 << ADDR_W)) begin : g_bad_nreg
      $error("NREG must lie between 1 and the address space");
   end

   localparam int IX_CS = 0;
   localparam int IX_WR = 1;
   localparam int IX_RD = 2;
   localparam int IX_ALE = 3;
   localparam int IX_SWR = 4;
   localparam int IX_SRD = 5;
   localparam int SYNC_N = 6;
   localparam logic [SYNC_N-1:0] SYNC_RESET = 6'h07;

   typedef enum logic [3:0] {
      P_IDLE = 4'b0001,
      P_SEL = 4'b0010,
      P_WAIT = 4'b0100,
      P_DONE = 4'b1000
   } par_state_e;

   logic [DATA_W-1:0] regs_r [NREG];
   logic [DATA_W-1:0] rd_word_r;

   function automatic logic [DATA_W-1:0] reg_read(input logic [ADDR_W-1:0] a);
      reg_read = (int'(a) < NREG) ? regs_r[a] : '0;
   endfunction

   // Link side, clocked by the serial clock. Raising select ends a frame even
   // when the clock has stopped.
   logic frame_rst_n;
   logic [BIT_W-1:0] bit_cnt_r;
   logic [ADDR_W-1:0] ser_addr_r;
   logic [DATA_W-1:0] ser_data_r;
   logic ser_rw_r;
   logic ser_wr_tog_r;
   logic ser_rd_tog_r;
   logic [1:0] edge_sel_sync_r;
   logic pos_bit_r;
   logic pos_oe_r;
   logic neg_bit_r;
   logic neg_oe_r;
   logic data_phase;
   logic [2:0] out_idx;
   logic [ADDR_W-1:0] ale_addr_r;

   assign frame_rst_n = rst_n_i & bus.chip_select_n == 1'b0;
   assign data_phase = ser_rw_r == RW_READ && bit_cnt_r >= DATA_POS && bit_cnt_r < FRAME_LEN;
   assign out_idx = 3'(bit_cnt_r - DATA_POS);

   always_ff @(posedge bus.link_clk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bit_cnt_r <= '0;
      end else if (bit_cnt_r != FRAME_LEN) begin
         bit_cnt_r <= bit_cnt_r + 5'h01;
      end
   end

   always_ff @(posedge bus.link_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ser_addr_r <= '0;
         ser_data_r <= '0;
         ser_rw_r <= 1'b0;
      end else begin
         if (bit_cnt_r <= LAST_ADDR_POS) begin
            ser_addr_r <= {bus.serial_in, ser_addr_r[ADDR_W-1:1]};
         end
         if (bit_cnt_r == RW_POS) begin
            ser_rw_r <= bus.serial_in;
         end
         if (bit_cnt_r >= DATA_POS && bit_cnt_r < FRAME_LEN) begin
            ser_data_r <= {bus.serial_in, ser_data_r[DATA_W-1:1]};
         end
      end
   end

   // Toggles hand each finished address and each finished write to the main clock.
   always_ff @(posedge bus.link_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ser_rd_tog_r <= 1'b0;
         ser_wr_tog_r <= 1'b0;
      end else begin
         if (bit_cnt_r == LAST_ADDR_POS) begin
            ser_rd_tog_r <= !ser_rd_tog_r;
         end
         if (bit_cnt_r == FRAME_LEN - 5'h01 && ser_rw_r != RW_READ) begin
            ser_wr_tog_r <= !ser_wr_tog_r;
         end
      end
   end

   always_ff @(posedge bus.link_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         edge_sel_sync_r <= '0;
      end else begin
         edge_sel_sync_r <= {edge_sel_sync_r[0], out_edge_select_i};
      end
   end

   // The latch strobe itself takes the address, before the bus turns to data.
   always_ff @(negedge bus.link_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ale_addr_r <= '0;
      end else begin
         ale_addr_r <= bus.ad[ADDR_W-1:0];
      end
   end

   // The read word was settled by the main clock more than one bit time before use.
   always_ff @(posedge bus.link_clk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         pos_bit_r <= 1'b0;
         pos_oe_r <= 1'b0;
      end else if (data_phase) begin
         pos_bit_r <= rd_word_r[out_idx];
         pos_oe_r <= 1'b1;
      end
   end

   always_ff @(negedge bus.link_clk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         neg_bit_r <= 1'b0;
         neg_oe_r <= 1'b0;
      end else if (data_phase) begin
         neg_bit_r <= rd_word_r[out_idx];
         neg_oe_r <= 1'b1;
      end
   end

   assign bus.sdo_d = edge_sel_sync_r[1] ? neg_bit_r : pos_bit_r;
   assign bus.sdo_oe = mode_i == BUS_SERIAL && (edge_sel_sync_r[1] ? neg_oe_r : pos_oe_r);

   // Main clock side: the select, strobe and link clock pins and both toggles pass two flip-flops first.
   logic [SYNC_N-1:0] s1_r;
   logic [SYNC_N-1:0] s2_r;
   logic [SYNC_N-1:0] s3_r;
   logic cs_lo;
   logic strobe_lo;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_r <= SYNC_RESET;
         s2_r <= SYNC_RESET;
         s3_r <= SYNC_RESET;
      end else begin
         s1_r <= {ser_rd_tog_r, ser_wr_tog_r, bus.link_clk, bus.read_strobe_n,
                  bus.write_strobe_n, bus.chip_select_n};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign cs_lo = !s2_r[IX_CS];
   assign strobe_lo = !s2_r[IX_WR] || !s2_r[IX_RD];

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_word_r <= REG_RESET;
      end else if (s2_r[IX_SRD] != s3_r[IX_SRD]) begin
         rd_word_r <= reg_read(ser_addr_r);
      end
   end

   par_state_e state_r;
   logic [ADDR_W-1:0] par_addr_r;
   logic par_is_rd_r;
   logic last_wr_r;
   logic [CNT_W-1:0] wait_cnt_r;
   logic par_commit;

   assign par_commit = state_r == P_WAIT && cs_lo && wait_cnt_r == '0 && !par_is_rd_r;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= P_IDLE;
         par_addr_r <= '0;
         par_is_rd_r <= 1'b0;
         last_wr_r <= 1'b0;
         wait_cnt_r <= '0;
         bus.rdy_d <= 1'b1;
         bus.rdy_oe <= 1'b0;
         bus.ad_d <= '0;
         bus.ad_d_oe <= 1'b0;
      end else if (!cs_lo && state_r != P_IDLE) begin
         state_r <= P_IDLE;
         bus.rdy_oe <= 1'b0;
         bus.ad_d_oe <= 1'b0;
      end else begin
         unique case (state_r)
            P_IDLE: begin
               if (cs_lo && mode_i != BUS_SERIAL) begin
                  state_r <= P_SEL;
                  bus.rdy_d <= 1'b1;
                  bus.rdy_oe <= 1'b1;
               end
            end
            P_SEL: begin
               if (mode_i == BUS_MUX && s3_r[IX_ALE] && !s2_r[IX_ALE]) begin
                  par_addr_r <= ale_addr_r;
               end
               if (strobe_lo) begin
                  if (mode_i == BUS_SEPARATE) begin
                     par_addr_r <= bus.addr;
                  end
                  par_is_rd_r <= !s2_r[IX_RD];
                  wait_cnt_r <= (!s2_r[IX_RD] && last_wr_r) ? RD_AFTER_WR_CYC : '0;
                  bus.rdy_d <= 1'b0;
                  state_r <= P_WAIT;
               end
            end
            P_WAIT: begin
               if (wait_cnt_r != '0) begin
                  wait_cnt_r <= wait_cnt_r - 4'h1;
               end else begin
                  if (par_is_rd_r) begin
                     bus.ad_d <= reg_read(par_addr_r);
                     bus.ad_d_oe <= 1'b1;
                  end
                  last_wr_r <= !par_is_rd_r;
                  bus.rdy_d <= 1'b1;
                  state_r <= P_DONE;
               end
            end
            P_DONE: begin
               if (!strobe_lo) begin
                  bus.ad_d_oe <= 1'b0;
                  state_r <= P_SEL;
               end
            end
         endcase
      end
   end

   // One commit path feeds the register file from all three bus forms.
   logic cm_en;
   logic [ADDR_W-1:0] cm_addr;
   logic [DATA_W-1:0] cm_data;

   always_comb begin
      cm_en = par_commit;
      cm_addr = par_addr_r;
      cm_data = bus.ad;
      if (mode_i == BUS_SERIAL) begin
         cm_en = s2_r[IX_SWR] != s3_r[IX_SWR];
         cm_addr = ser_addr_r;
         cm_data = ser_data_r;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NREG; i++) begin
            regs_r[i] <= REG_RESET;
         end
      end else if (cm_en && int'(cm_addr) < NREG) begin
         regs_r[cm_addr] <= cm_data;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_wr_o <= 1'b0;
         reg_addr_o <= '0;
         reg_data_o <= '0;
      end else begin
         reg_wr_o <= cm_en;
         if (cm_en) begin
            reg_addr_o <= cm_addr;
            reg_data_o <= cm_data;
         end
      end
   end
endmodule // host_port_dev
`default_nettype wire

// file: hw/host_port_pkg.sv
`default_nettype none
package host_port_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int BIT_W = 5;
   localparam int CNT_W = 4;
   localparam int CLK_PERIOD_NS = 100;
   localparam int RD_AFTER_WR_NS = 193;
   localparam int WR_GAP_NS = 160;
   localparam int RD_GAP_NS = 20;

   // Least times round up, longest times round down, never below one cycle.
   function automatic int cyc_least(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int cyc_most(input int ns);
      int c;
      c = ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam logic [CNT_W-1:0] RD_AFTER_WR_CYC = CNT_W'(cyc_most(RD_AFTER_WR_NS));
   localparam logic [CNT_W-1:0] WR_GAP_CYC = CNT_W'(cyc_least(WR_GAP_NS));
   localparam logic [CNT_W-1:0] RD_GAP_CYC = CNT_W'(cyc_least(RD_GAP_NS));

   localparam logic [BIT_W-1:0] LAST_ADDR_POS = 5'h06;
   localparam logic [BIT_W-1:0] RW_POS = 5'h07;
   localparam logic [BIT_W-1:0] DATA_POS = 5'h08;
   localparam logic [BIT_W-1:0] FRAME_LEN = 5'h10;
   localparam logic RW_READ = 1'b1;
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

   typedef enum logic [2:0] {
      BUS_SEPARATE = 3'b001,
      BUS_MUX = 3'b010,
      BUS_SERIAL = 3'b100
   } bus_form_e;
endpackage
`default_nettype wire

// file: hw/host_port_if.sv
`default_nettype none
interface host_port_if;
   logic chip_select_n;
   logic write_strobe_n;
   logic read_strobe_n;
   logic link_clk;
   logic serial_in;
   logic [host_port_pkg::ADDR_W-1:0] addr;
   logic [host_port_pkg::DATA_W-1:0] ad_h;
   logic ad_h_oe;
   logic [host_port_pkg::DATA_W-1:0] ad_d;
   logic ad_d_oe;
   logic [host_port_pkg::DATA_W-1:0] ad;
   logic rdy_d;
   logic rdy_oe;
   logic ready;
   logic sdo_d;
   logic sdo_oe;
   logic serial_out;

   // Undriven lines settle at their pull levels.
   assign ad = ad_d_oe ? ad_d : (ad_h_oe ? ad_h : '0);
   assign ready = rdy_oe ? rdy_d : 1'b1;
   assign serial_out = sdo_oe ? sdo_d : 1'b0;

   modport dev (
      input chip_select_n, write_strobe_n, read_strobe_n, link_clk, serial_in, addr, ad,
      output ad_d, ad_d_oe, rdy_d, rdy_oe, sdo_d, sdo_oe
   );
   modport host (
      output chip_select_n, write_strobe_n, read_strobe_n, link_clk, serial_in, addr,
      output ad_h, ad_h_oe,
      input ad, ready, serial_out
   );
endinterface
`default_nettype wire

// file: hw/host_port_host.sv
`default_nettype none
module host_port_host #(
   parameter int HALF = 4
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   host_port_if.host bus,
   input wire host_port_pkg::bus_form_e mode_i,
   input wire logic out_edge_select_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic [host_port_pkg::ADDR_W-1:0] cmd_addr_i,
   input wire logic [host_port_pkg::DATA_W-1:0] cmd_data_i,
   output logic cmd_ready_o,
   output logic rsp_valid_o,
   output logic [host_port_pkg::DATA_W-1:0] rsp_data_o
);
   import host_port_pkg::*;

   if (HALF < 4 || HALF > 15) begin : g_bad_half
      $error("HALF must lie between 4 and 15");
   end

   localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF - 1);

   typedef enum logic [6:0] {
      H_IDLE = 7'b0000001,
      H_ALE = 7'b0000010,
      H_STROBE = 7'b0000100,
      H_WAIT_LO = 7'b0001000,
      H_WAIT_HI = 7'b0010000,
      H_RELEASE = 7'b0100000,
      H_SER = 7'b1000000
   } host_state_e;

   host_state_e state_r;
   logic [1:0] rdy_sync_r;
   logic [1:0] sdo_sync_r;
   logic [DATA_W-1:0] ad_s1_r;
   logic [DATA_W-1:0] ad_s2_r;
   logic write_r;
   logic [DATA_W-1:0] data_r;
   logic [15:0] frame_r;
   logic [BIT_W-1:0] bit_r;
   logic [CNT_W-1:0] cnt_r;
   logic [DATA_W-1:0] rd_sh_r;
   logic in_gap_r;
   logic cap_now;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdy_sync_r <= 2'h3;
         sdo_sync_r <= '0;
         ad_s1_r <= '0;
         ad_s2_r <= '0;
      end else begin
         rdy_sync_r <= {rdy_sync_r[0], bus.ready};
         sdo_sync_r <= {sdo_sync_r[0], bus.serial_out};
         ad_s1_r <= bus.ad;
         ad_s2_r <= ad_s1_r;
      end
   end

   // Read data is caught at the edge opposite to the one that launched it.
   assign cap_now = state_r == H_SER && cnt_r == HALF_LAST && !write_r && bit_r >= DATA_POS
                    && (bus.link_clk != out_edge_select_i);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_sh_r <= '0;
      end else if (cap_now) begin
         rd_sh_r <= {sdo_sync_r[1], rd_sh_r[DATA_W-1:1]};
      end else if (state_r == H_WAIT_HI && rdy_sync_r[1]) begin
         rd_sh_r <= ad_s2_r;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= H_IDLE;
         cmd_ready_o <= 1'b0;
         rsp_valid_o <= 1'b0;
         rsp_data_o <= '0;
         write_r <= 1'b0;
         data_r <= '0;
         frame_r <= '0;
         bit_r <= '0;
         cnt_r <= '0;
         in_gap_r <= 1'b0;
         bus.chip_select_n <= 1'b1;
         bus.write_strobe_n <= 1'b1;
         bus.read_strobe_n <= 1'b1;
         bus.link_clk <= 1'b0;
         bus.serial_in <= 1'b0;
         bus.addr <= '0;
         bus.ad_h <= '0;
         bus.ad_h_oe <= 1'b0;
      end else begin
         rsp_valid_o <= 1'b0;
         unique case (state_r)
            H_IDLE: begin
               if (in_gap_r) begin
                  cnt_r <= cnt_r - 4'h1;
                  in_gap_r <= cnt_r != 4'h1;
                  cmd_ready_o <= cnt_r == 4'h1;
               end else if (!cmd_ready_o) begin
                  cmd_ready_o <= 1'b1;
               end else if (cmd_valid_i) begin
                  cmd_ready_o <= 1'b0;
                  write_r <= cmd_write_i;
                  data_r <= cmd_data_i;
                  bus.chip_select_n <= 1'b0;
                  cnt_r <= '0;
                  if (mode_i == BUS_SERIAL) begin
                     frame_r <= {cmd_data_i, !cmd_write_i, cmd_addr_i};
                     bus.serial_in <= cmd_addr_i[0];
                     bit_r <= '0;
                     state_r <= H_SER;
                  end else if (mode_i == BUS_MUX) begin
                     bus.ad_h <= DATA_W'(cmd_addr_i);
                     bus.ad_h_oe <= 1'b1;
                     bus.link_clk <= 1'b1;
                     state_r <= H_ALE;
                  end else begin
                     bus.addr <= cmd_addr_i;
                     state_r <= H_STROBE;
                  end
               end
            end
            H_ALE: begin
               bus.link_clk <= 1'b0;
               state_r <= H_STROBE;
            end
            H_STROBE: begin
               bus.ad_h <= data_r;
               bus.ad_h_oe <= write_r;
               bus.write_strobe_n <= !write_r;
               bus.read_strobe_n <= write_r;
               state_r <= H_WAIT_LO;
            end
            H_WAIT_LO: begin
               if (!rdy_sync_r[1]) begin
                  state_r <= H_WAIT_HI;
               end
            end
            H_WAIT_HI: begin
               if (rdy_sync_r[1]) begin
                  bus.write_strobe_n <= 1'b1;
                  bus.read_strobe_n <= 1'b1;
                  state_r <= H_RELEASE;
               end
            end
            H_RELEASE: begin
               bus.chip_select_n <= 1'b1;
               bus.ad_h_oe <= 1'b0;
               rsp_valid_o <= !write_r;
               rsp_data_o <= rd_sh_r;
               cnt_r <= write_r ? WR_GAP_CYC : RD_GAP_CYC;
               in_gap_r <= 1'b1;
               state_r <= H_IDLE;
            end
            H_SER: begin
               cnt_r <= (cnt_r == HALF_LAST) ? '0 : cnt_r + 4'h1;
               if (cnt_r == HALF_LAST) begin
                  bus.link_clk <= !bus.link_clk;
                  if (bus.link_clk) begin
                     if (bit_r == FRAME_LEN - 5'h01) begin
                        state_r <= H_RELEASE;
                     end else begin
                        bit_r <= bit_r + 5'h01;
                        bus.serial_in <= frame_r[4'(bit_r + 5'h01)];
                     end
                  end
               end
            end
         endcase
      end
   end
endmodule // host_port_host
`default_nettype wire

// file: tb/host_port_props.sv
`default_nettype none
module host_port_props (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire host_port_pkg::bus_form_e mode_i,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic link_clk,
   input wire logic ad_d_oe,
   input wire logic rdy_d,
   input wire logic rdy_oe,
   input wire logic sdo_oe
);
   import host_port_pkg::*;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   select_ready_a: assert property ($fell(chip_select_n) && mode_i != BUS_SERIAL
      |-> ##[1:4] rdy_oe) else $error("ready not driven after select");
   strobe_ready_a: assert property ($fell(write_strobe_n && read_strobe_n)
      && mode_i != BUS_SERIAL |-> ##[1:4] (rdy_oe && !rdy_d)) else $error("ready not low");
   ready_done_a: assert property (rdy_oe && !rdy_d |-> ##[1:6] (rdy_oe && rdy_d))
      else $error("ready did not return high");
   ready_release_a: assert property ($rose(chip_select_n) |-> ##[1:4] !rdy_oe)
      else $error("ready not released");
   data_ready_a: assert property (rdy_oe && $past(rdy_oe) && $rose(rdy_d)
      && !read_strobe_n |-> ad_d_oe) else $error("read data late");
   parallel_sdo_a: assert property (sdo_oe |-> mode_i == BUS_SERIAL && !chip_select_n)
      else $error("serial output driven outside a serial frame");
   sdo_release_a: assert property ($rose(chip_select_n) |-> ##[0:4] !sdo_oe)
      else $error("serial output not released");
   write_hold_a: assert property ($rose(write_strobe_n) |-> $past(rdy_oe && rdy_d))
      else $error("write strobe ended before ready");
   select_hold_a: assert property ($rose(chip_select_n)
      |-> $past(write_strobe_n && read_strobe_n)) else $error("select ended before strobe");
   latch_first_a: assert property (mode_i == BUS_MUX && $fell(write_strobe_n)
      |-> !link_clk && $past(!link_clk)) else $error("write strobe before latch fall");
   write_gap_a: assert property ($rose(write_strobe_n)
      |-> (write_strobe_n && read_strobe_n)[*2]) else $error("strobe gap after write too short");
   mux_gap_a: assert property (mode_i == BUS_MUX && $rose(write_strobe_n)
      |-> (!link_clk)[*2]) else $error("latch strobe too soon after write");
   idle_clock_a: assert property (mode_i == BUS_SERIAL && chip_select_n
      && $past(chip_select_n) |-> $stable(link_clk)) else $error("link clock ran while idle");

   mux_read_c: cover property (mode_i == BUS_MUX && $rose(rdy_d) && !read_strobe_n);
   serial_read_c: cover property (mode_i == BUS_SERIAL && $rose(sdo_oe));
   write_end_c: cover property ($rose(write_strobe_n));
endmodule // host_port_props
`default_nettype wire

// file: tb/host_bus_interface_tb.sv
`default_nettype none
module host_bus_interface_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import host_port_pkg::*;

   localparam int LIMIT = 30000;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   bus_form_e mode = BUS_SEPARATE;
   logic edge_sel = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic [ADDR_W-1:0] cmd_addr = '0;
   logic [DATA_W-1:0] cmd_data = '0;
   logic cmd_ready, rsp_valid, reg_wr;
   logic [DATA_W-1:0] rsp_data, reg_data;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] mem [128];
   logic [15:0] frame = '0;
   logic [ADDR_W-1:0] latched = '0;
   logic [31:0] seed = 32'h0000004f;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;

   host_port_if ifc();

   host_port_host u_host_port_host (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(ifc),
      .mode_i(mode), .out_edge_select_i(edge_sel), .cmd_valid_i(cmd_valid),
      .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
      .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data));

   host_port_dev #(.NREG(128)) u_host_port_dev (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .bus(ifc), .mode_i(mode), .out_edge_select_i(edge_sel), .reg_wr_o(reg_wr),
      .reg_addr_o(reg_addr), .reg_data_o(reg_data));

   host_port_props u_host_port_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .mode_i(mode),
      .chip_select_n(ifc.chip_select_n), .write_strobe_n(ifc.write_strobe_n),
      .read_strobe_n(ifc.read_strobe_n), .link_clk(ifc.link_clk), .ad_d_oe(ifc.ad_d_oe),
      .rdy_d(ifc.rdy_d), .rdy_oe(ifc.rdy_oe), .sdo_oe(ifc.sdo_oe));

   always #50 mclk_i = ~mclk_i;

   // Serial input bits as seen on the wire at each rising link clock.
   always @(posedge ifc.link_clk) begin
      if (mode == BUS_SERIAL && ifc.chip_select_n === 1'b0) begin
         frame <= {ifc.serial_in, frame[15:1]};
      end
   end

   // Multiplexed address as it stands when the latch strobe falls.
   always @(negedge ifc.link_clk) begin
      if (mode == BUS_MUX) begin
         latched <= ifc.ad[ADDR_W-1:0];
      end
   end

   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fail_count++;
         report_and_stop();
      end
   end

   function automatic logic [31:0] next_rand(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   // Expected frame: address, read/write bit, then data, each LSB first.
   function automatic logic [15:0] frame_exp(input logic wr, input logic [ADDR_W-1:0] a,
                                            input logic [DATA_W-1:0] d);
      return wr ? {d, ~RW_READ, a} : {8'h00, RW_READ, a};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("Checks made: %0d, mismatches: %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      @(negedge mclk_i);
      while (cmd_ready !== 1'b1 && n < 400) begin
         @(negedge mclk_i);
         n++;
      end
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_addr = a;
      cmd_data = d;
      @(negedge mclk_i);
      cmd_valid = 1'b0;
      n = 0;
      if (wr) begin
         while (reg_wr !== 1'b1 && n < 400) begin
            @(negedge mclk_i);
            n++;
         end
         check({15'h0, reg_wr}, 16'h0001);
         check({9'h0, reg_addr}, {9'h0, a});
         check({8'h0, reg_data}, {8'h0, d});
         mem[a] = d;
      end else begin
         while (rsp_valid !== 1'b1 && n < 400) begin
            @(negedge mclk_i);
            n++;
         end
         check({8'h0, rsp_data}, {8'h0, mem[a]});
      end
      n = 0;
      while (ifc.chip_select_n !== 1'b1 && n < 400) begin
         @(negedge mclk_i);
         n++;
      end
      if (mode == BUS_SERIAL) begin
         check(wr ? frame : {8'h00, frame[7:0]}, frame_exp(wr, a, d));
      end
      if (mode == BUS_MUX) begin
         check({9'h0, latched}, {9'h0, a});
      end
   endtask

   task automatic rand_ops(input int n, input logic wonly);
      logic [ADDR_W-1:0] a;
      for (int i = 0; i < n; i++) begin
         seed = next_rand(seed);
         a = seed[6:0];
         access(1'b1, a, seed[15:8]);
         if (!wonly) begin
            seed = next_rand(seed);
            access(1'b0, seed[0] ? a : seed[14:8], 8'h00);
         end
      end
   endtask

   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = REG_RESET;
      end
      repeat (20) @(posedge mclk_i);
      @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge mclk_i);
      access(1'b1, 7'h7f, 8'ha5);
      rand_ops(4, 1'b1);
      mode = BUS_MUX;
      access(1'b1, 7'h00, 8'hff);
      access(1'b0, 7'h00, 8'h00);
      access(1'b0, 7'h7f, 8'h00);
      access(1'b0, 7'h55, 8'h00);
      rand_ops(8, 1'b0);
      for (int e = 0; e < 2; e++) begin
         mode = BUS_SERIAL;
         edge_sel = e[0];
         access(1'b1, 7'h01, e[0] ? 8'h3c : 8'hc3);
         access(1'b0, 7'h01, 8'h00);
         access(1'b0, 7'h7f, 8'h00);
         rand_ops(4, 1'b0);
      end
      report_and_stop();
   end
endmodule // host_bus_interface_tb
`default_nettype wire
